// ---- design/flash_mode_command_decoder.sv ----
// mode command decoder for a 16-bit flash: config, lock, secure region and query
// assumes one-cycle write/read strobes synchronous to i_clock
// Notes on behaviour
// - D0 at unlock address enters configuration mode when all banks idle.
// - in configuration mode 25, count 0, data at X00, then 29 commits.
// - 40 at unlock address enters lock mode; lock word read at base.
// - in lock mode, load FE at offset 00 count 0, then commit.
// - 88 at unlock address enters secure region mode for reads and programs.
// - buffered program length follows loaded word count, 4 to 35 cycles.
// - program resume acts only while program suspended.
// - erase resume acts only while erase suspended.
// - mode entry only when banks idle; mode commands only after entry.
// - blank check works only when the async read select bit is set.
// - upper data byte ignored in command writes.
// - command match uses address bits 10..0 only (7..0 for query); sector select is ignored.
// - command cycles are writes except the listed read cycles.
// - 90 or 98 at offset 55 while idle enters query mode.
// - identification fills first 32 bytes, query structure follows.
// - query offsets 10..12 return Q, R, Y.
// - query points to extended table at 40, no alternate set.
`timescale 1ns/10ps
module flash_mode_command_decoder (
  input  wire logic                               i_clock,
  input  wire logic                               i_reset,
  input  wire logic                               i_write,
  input  wire logic                               i_read,
  input  wire logic [flash_cmd_pkg::ADDR_W-1:0]   i_address,
  input  wire logic [15:0]                        i_data,
  input  wire logic                               i_banks_idle,
  input  wire logic [15:0]                        i_array_data,
  input  wire logic [15:0]                        i_secure_data,
  output logic      [15:0]                        o_read_data,
  output logic                                    o_read_valid,
  output logic                                    o_secure_select,
  output logic                                    o_prog_word,
  output logic      [flash_cmd_pkg::ADDR_W-1:0]   o_program_target_address,
  output logic      [15:0]                        o_program_write_value,
  output logic                                    o_buffer_commit,
  output logic                                    o_prog_resume,
  output logic                                    o_erase_resume,
  output logic                                    o_blank_check,
  output logic      [15:0]                        o_config_word,
  output logic      [15:0]                        o_lock_word,
  output logic      [1:0]                         o_mode
);
  import flash_cmd_pkg::*;

  typedef enum logic [2:0] {M_ARRAY, M_CONFIG, M_LOCK, M_SECURE, M_QUERY} mode_t;
  typedef enum logic [2:0] {B_IDLE, B_COUNT, B_DATA, B_WORDS, B_COMMIT} buf_t;

  typedef struct packed {
    mode_t                mode;
    buf_t                 bstate;
    logic                 prog_susp;
    logic                 erase_susp;
    logic [15:0]          config_word;
    logic [15:0]          lock_word;
    logic [15:0]          staged;
    logic [15:0]          read_data;
    logic                 read_valid;
    logic                 prog_word;
    logic [ADDR_W-1:0]    prog_addr;
    logic [15:0]          prog_value;
    logic                 commit;
    logic                 prog_resume;
    logic                 erase_resume;
    logic                 blank_check;
    logic                 loaded;
    logic [1:0]           mode_code;
    logic                 secure;
  } state_t;

  state_t s;
  state_t next_s;

  // compares only the low 11 bits; the sector and the offset bits above bit 10 are ignored
  function automatic logic low_match(input logic [ADDR_W-1:0] a, input logic [10:0] v);
    low_match = a[LOW_MSB:0] == v;
  endfunction

  logic [7:0]  cmd;
  logic [15:0] rom_data;
  logic        seq_busy;
  logic        seq_last;
  logic        seq_start;
  logic        in_page;

  assign cmd = i_data[7:0];

  query_rom u_rom (
    .i_offset (i_address[7:0]),
    .o_data   (rom_data)
  );

  buffer_sequencer u_seq (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_start (seq_start),
    .i_count (i_data[4:0]),
    .i_word  (i_write && s.bstate == B_WORDS),
    .o_busy  (seq_busy),
    .o_last  (seq_last)
  );

  // same sector and page as the first word; a stray word is dropped
  assign in_page = i_address[ADDR_W-1:PAGE_BITS] == s.prog_addr[ADDR_W-1:PAGE_BITS];

  assign seq_start = i_write && s.bstate == B_COUNT &&
                     (s.mode == M_ARRAY || s.mode == M_SECURE) &&
                     i_data[7:5] == 3'h0;

  always_comb begin
    next_s = s;
    next_s.read_valid   = 1'b0;
    next_s.prog_word    = 1'b0;
    next_s.commit       = 1'b0;
    next_s.prog_resume  = 1'b0;
    next_s.erase_resume = 1'b0;
    next_s.blank_check  = 1'b0;
    if (i_read) begin
      next_s.read_valid = 1'b1;
      case (s.mode)
        M_QUERY:  next_s.read_data = rom_data;
        M_CONFIG: next_s.read_data = s.config_word;
        M_LOCK:   next_s.read_data = (i_address[7:0] == LOCK_OFFSET) ? s.lock_word : 16'h0000;
        M_SECURE: next_s.read_data = i_secure_data;
        default:  next_s.read_data = i_array_data;
      endcase
    end else if (i_write) begin
      if (cmd == CMD_EXIT) begin
        next_s.mode   = M_ARRAY;
        next_s.bstate = B_IDLE;
      end else begin
        case (s.bstate)
          B_IDLE: begin
            if (low_match(i_address, UNLOCK_ADDR) && cmd == CMD_BUF_LOAD &&
                s.mode != M_QUERY)
              next_s.bstate = B_COUNT;
            else if (low_match(i_address, UNLOCK_ADDR) && cmd == CMD_BUF_COMMIT) begin
              // outside a load, commit applies the staged word in configuration mode only
              if (s.mode == M_CONFIG && s.staged != s.config_word)
                next_s.config_word = s.staged;
            end
            else if (s.mode == M_ARRAY && i_banks_idle) begin
              if (low_match(i_address, UNLOCK_ADDR) && cmd == CMD_CONFIG_ENTRY)
                next_s.mode = M_CONFIG;
              else if (low_match(i_address, UNLOCK_ADDR) && cmd == CMD_LOCK_ENTRY)
                next_s.mode = M_LOCK;
              else if (low_match(i_address, UNLOCK_ADDR) && cmd == CMD_SECURE_ENTRY)
                next_s.mode = M_SECURE;
              else if (i_address[7:0] == QUERY_ADDR &&
                       (cmd == CMD_QUERY_A || cmd == CMD_QUERY_B))
                next_s.mode = M_QUERY;
            end
            if (s.mode == M_ARRAY) begin
              if (cmd == CMD_PROG_SUSPEND) next_s.prog_susp = 1'b1;
              if (cmd == CMD_ERASE_SUSP) next_s.erase_susp = 1'b1;
              if (cmd == CMD_PROG_RESUME && s.prog_susp) begin
                next_s.prog_resume = 1'b1;
                next_s.prog_susp   = 1'b0;
              end
              if (cmd == CMD_ERASE_RESUME && s.erase_susp) begin
                next_s.erase_resume = 1'b1;
                next_s.erase_susp   = 1'b0;
              end
              if (cmd == CMD_BLANK_CHECK && low_match(i_address, UNLOCK_ADDR) &&
                  s.config_word[ASYNC_BIT])
                next_s.blank_check = 1'b1;
            end
          end
          B_COUNT: begin
            if (!low_match(i_address, UNLOCK_ADDR2) && !low_match(i_address, UNLOCK_ADDR))
              next_s.bstate = B_IDLE;
            else if (s.mode == M_CONFIG || s.mode == M_LOCK)
              next_s.bstate = (cmd == 8'h00) ? B_DATA : B_IDLE;
            else if (seq_start) begin
              next_s.bstate = B_WORDS;
              next_s.loaded = 1'b0;
            end
            else
              next_s.bstate = B_IDLE;
          end
          B_DATA: begin
            next_s.bstate = B_COMMIT;
            if (s.mode == M_CONFIG && i_address[7:0] == CFG_OFFSET)
              next_s.staged = i_data;
            else if (s.mode == M_LOCK && i_address[7:0] == LOCK_OFFSET &&
                     cmd == LOCK_SET_VALUE)
              next_s.staged = {8'h00, LOCK_SET_VALUE};
            else
              next_s.bstate = B_IDLE;
          end
          B_WORDS: begin
            // a stray word ends the load, so nothing lands outside the first page
            if (!seq_busy || (s.loaded && !in_page)) next_s.bstate = B_IDLE;
            else begin
              next_s.prog_word  = 1'b1;
              next_s.loaded     = 1'b1;
              next_s.prog_addr  = i_address;
              next_s.prog_value = i_data;
              if (seq_last) next_s.bstate = B_COMMIT;
            end
          end
          B_COMMIT: begin
            next_s.bstate = B_IDLE;
            if (low_match(i_address, UNLOCK_ADDR) && cmd == CMD_BUF_COMMIT) begin
              if (s.mode == M_CONFIG) next_s.config_word = s.staged;
              else if (s.mode == M_LOCK) next_s.lock_word = s.lock_word & ~16'h0001;
              else next_s.commit = 1'b1;
            end
          end
          default: next_s.bstate = B_IDLE;
        endcase
      end
    end
    // mode pins come from flops so they never glitch on a decode
    next_s.secure    = next_s.mode == M_SECURE;
    next_s.mode_code = (next_s.mode == M_QUERY)  ? 2'h1 :
                       (next_s.mode == M_CONFIG) ? 2'h2 :
                       (next_s.mode == M_LOCK)   ? 2'h3 : 2'h0;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s             <= '0;
      s.config_word <= CONFIG_RESET;
      s.lock_word   <= LOCK_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign o_read_data              = s.read_data;
  assign o_read_valid             = s.read_valid;
  assign o_secure_select          = s.secure;
  assign o_prog_word              = s.prog_word;
  assign o_program_target_address = s.prog_addr;
  assign o_program_write_value    = s.prog_value;
  assign o_buffer_commit          = s.commit;
  assign o_prog_resume            = s.prog_resume;
  assign o_erase_resume           = s.erase_resume;
  assign o_blank_check            = s.blank_check;
  assign o_config_word            = s.config_word;
  assign o_lock_word              = s.lock_word;
  assign o_mode                   = s.mode_code;

  // bus events shared by the entry and commit checks
  sequence s_unlock_write;
    i_write && !i_read && low_match(i_address, UNLOCK_ADDR);
  endsequence
  sequence s_entry_allowed;
    s.mode == M_ARRAY && s.bstate == B_IDLE && i_banks_idle;
  endsequence
  sequence s_commit_due;
    s.bstate == B_COMMIT && cmd == CMD_BUF_COMMIT;
  endsequence

  a_exit_to_array: assert property (@(posedge i_clock) disable iff (i_reset)
    i_write && !i_read && i_data[7:0] == CMD_EXIT |=> s.mode == M_ARRAY)
    else $error("exit write did not return to array mode");
  a_entry_needs_idle: assert property (@(posedge i_clock) disable iff (i_reset)
    s.mode == M_ARRAY && !i_banks_idle |=> s.mode == M_ARRAY || $past(i_read))
    else $error("mode entered while banks busy");
  a_prog_resume_gate: assert property (@(posedge i_clock) disable iff (i_reset)
    s.prog_resume |-> $past(s.prog_susp))
    else $error("program resume without suspend");
  a_erase_resume_gate: assert property (@(posedge i_clock) disable iff (i_reset)
    s.erase_resume |-> $past(s.erase_susp))
    else $error("erase resume without suspend");
  a_blank_async_only: assert property (@(posedge i_clock) disable iff (i_reset)
    s.blank_check |-> $past(s.config_word[ASYNC_BIT]))
    else $error("blank check with synchronous read selected");
  a_query_sig_q: assert property (@(posedge i_clock) disable iff (i_reset)
    i_read && s.mode == M_QUERY && i_address[7:0] == 8'h10 |=> s.read_data == 16'h0051)
    else $error("query signature wrong");
  a_query_pointer: assert property (@(posedge i_clock) disable iff (i_reset)
    i_read && s.mode == M_QUERY && i_address[7:0] == 8'h15 |=> s.read_data == 16'h0040)
    else $error("extended table pointer wrong");
  a_read_one_cycle: assert property (@(posedge i_clock) disable iff (i_reset)
    i_read |=> s.read_valid ##1 (s.read_valid == $past(i_read)))
    else $error("read answer timing wrong");
  a_config_entry: assert property (@(posedge i_clock) disable iff (i_reset)
    s_entry_allowed ##0 s_unlock_write ##0 (cmd == CMD_CONFIG_ENTRY) |=> s.mode == M_CONFIG)
    else $error("configuration entry not taken");
  a_lock_entry: assert property (@(posedge i_clock) disable iff (i_reset)
    s_entry_allowed ##0 s_unlock_write ##0 (cmd == CMD_LOCK_ENTRY) |=> s.mode == M_LOCK)
    else $error("lock entry not taken");
  a_secure_entry: assert property (@(posedge i_clock) disable iff (i_reset)
    s_entry_allowed ##0 s_unlock_write ##0 (cmd == CMD_SECURE_ENTRY) |=> s.mode == M_SECURE)
    else $error("secure region entry not taken");
  a_config_commit: assert property (@(posedge i_clock) disable iff (i_reset)
    s_commit_due ##0 s_unlock_write ##0 (s.mode == M_CONFIG) |=> s.config_word == $past(s.staged))
    else $error("configuration word not committed");
  a_lock_commit: assert property (@(posedge i_clock) disable iff (i_reset)
    s_commit_due ##0 s_unlock_write ##0 (s.mode == M_LOCK) |=>
      s.lock_word == ($past(s.lock_word) & 16'hfffe))
    else $error("lock word not set");
  a_secure_commit: assert property (@(posedge i_clock) disable iff (i_reset)
    s_commit_due ##0 s_unlock_write ##0 (s.mode == M_SECURE) |=> s.commit)
    else $error("secure buffer commit missing");
  a_word_in_page: assert property (@(posedge i_clock) disable iff (i_reset)
    s.bstate == B_WORDS && s.loaded && i_write && !i_read && cmd != CMD_EXIT && !in_page |=>
      !s.prog_word && s.bstate == B_IDLE)
    else $error("buffer word outside page accepted");
endmodule

// ---- design/flash_cmd_pkg.sv ----
// constants for the flash mode command decoder
// assumes a 16-bit word bus with sector select bits above a 16-bit offset
package flash_cmd_pkg;
  localparam int ADDR_W        = 24;
  localparam int SECT_LSB      = 16;
  localparam int LOW_MSB       = 10;
  localparam logic [7:0] CMD_CONFIG_ENTRY = 8'hd0;
  localparam logic [7:0] CMD_BUF_LOAD     = 8'h25;
  localparam logic [7:0] CMD_BUF_COMMIT   = 8'h29;
  localparam logic [7:0] CMD_LOCK_ENTRY   = 8'h40;
  localparam logic [7:0] CMD_SECURE_ENTRY = 8'h88;
  localparam logic [7:0] CMD_QUERY_A      = 8'h90;
  localparam logic [7:0] CMD_QUERY_B      = 8'h98;
  localparam logic [7:0] CMD_EXIT         = 8'hf0;
  localparam logic [7:0] CMD_PROG_SUSPEND = 8'h51;
  localparam logic [7:0] CMD_PROG_RESUME  = 8'h50;
  localparam logic [7:0] CMD_ERASE_SUSP   = 8'hb0;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'h30;
  localparam logic [7:0] CMD_BLANK_CHECK  = 8'h33;
  localparam logic [7:0] LOCK_SET_VALUE   = 8'hfe;
  localparam logic [10:0] UNLOCK_ADDR     = 11'h555;
  localparam logic [10:0] UNLOCK_ADDR2    = 11'h2aa;
  localparam logic [7:0]  QUERY_ADDR      = 8'h55;
  localparam logic [7:0]  LOCK_OFFSET     = 8'h00;
  localparam logic [7:0]  CFG_OFFSET      = 8'h00;
  localparam int PAGE_BITS      = 5;
  localparam int MAX_WORDS      = 32;
  localparam int ID_WORDS       = 16;
  localparam int ASYNC_BIT      = 15;
  localparam logic [15:0] CONFIG_RESET   = 16'h8000;
  localparam logic [15:0] LOCK_RESET     = 16'hffff;
  localparam logic [15:0] ID_FILL        = 16'h00ff;
  // arbitrary identification values
  localparam logic [15:0] MAKER_CODE     = 16'h00a5;
  localparam logic [15:0] PART_CODE      = 16'h005a;
  localparam logic [15:0] Q_SIG_Q        = 16'h0051;
  localparam logic [15:0] Q_SIG_R        = 16'h0052;
  localparam logic [15:0] Q_SIG_Y        = 16'h0059;
  localparam logic [15:0] PRI_TABLE_ADDR = 16'h0040;
  localparam logic [15:0] CMD_SET_CODE   = 16'h0002;
  typedef enum logic [1:0] {RD_ARRAY, RD_QUERY, RD_CONFIG, RD_LOCK} read_sel_t;
endpackage

// ---- design/query_rom.sv ----
// identification and query word table, combinational lookup
// assumes a word offset within the selected sector
`timescale 1ns/10ps
module query_rom (
  input  wire logic [7:0]  i_offset,
  output logic      [15:0] o_data
);
  import flash_cmd_pkg::*;
  always_comb begin
    case (i_offset)
      8'h00:   o_data = MAKER_CODE;
      8'h01:   o_data = PART_CODE;
      8'h10:   o_data = Q_SIG_Q;
      8'h11:   o_data = Q_SIG_R;
      8'h12:   o_data = Q_SIG_Y;
      8'h13:   o_data = CMD_SET_CODE;
      8'h15:   o_data = PRI_TABLE_ADDR;
      8'h14, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a:
               o_data = 16'h0000;
      default: o_data = (i_offset < 8'(ID_WORDS)) ? ID_FILL : 16'h0000;
    endcase
  end
endmodule

// ---- design/buffer_sequencer.sv ----
// counts buffer-load words after the count cycle
// assumes one write per cycle strobe
`timescale 1ns/10ps
module buffer_sequencer (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_start,
  input  wire logic [4:0] i_count,
  input  wire logic       i_word,
  output logic            o_busy,
  output logic            o_last
);
  import flash_cmd_pkg::*;
  typedef struct packed {
    logic       busy;
    logic [4:0] left;
  } seq_t;
  seq_t s;
  seq_t next_s;
  always_comb begin
    next_s = s;
    if (i_start) begin
      next_s.busy = 1'b1;
      next_s.left = i_count;
    end else if (s.busy && i_word) begin
      if (s.left == 5'h00) next_s.busy = 1'b0;
      else next_s.left = s.left - 5'h01;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_reset) s <= '0;
    else s <= next_s;
  end
  assign o_busy = s.busy;
  assign o_last = s.busy && i_word && s.left == 5'h00;
endmodule

// ---- tb/host_model.sv ----
// host side model: issues single write and read bus cycles to the decoder
// assumes one-cycle strobes sampled on the rising edge of i_clock
`timescale 1ns/10ps
module host_model (
  input  wire logic                             i_clock,
  input  wire logic      [15:0]                 i_read_data,
  input  wire logic                             i_read_valid,
  output logic                                  o_write,
  output logic                                  o_read,
  output logic      [flash_cmd_pkg::ADDR_W-1:0] o_address,
  output logic      [15:0]                      o_data
);
  import flash_cmd_pkg::*;

  initial begin
    o_write   = 1'b0;
    o_read    = 1'b0;
    o_address = '0;
    o_data    = '0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge i_clock);
    o_write   <= 1'b1;
    o_address <= a;
    o_data    <= d;
    @(posedge i_clock);
    o_write   <= 1'b0;
    // released bus shows the inverse so a stale value never looks valid
    o_address <= ~a;
    o_data    <= ~d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d, output logic v);
    @(posedge i_clock);
    o_read    <= 1'b1;
    o_address <= a;
    @(posedge i_clock);
    o_read    <= 1'b0;
    o_address <= ~a;
    #1;
    v = i_read_valid;
    d = i_read_data;
  endtask

  // load command and count cycle, then words ascending from the lowest one, all in one page
  task automatic load(input logic [ADDR_W-1:0] start, input int n, input logic [15:0] d0);
    int i;
    wr({start[23:16], 5'h00, UNLOCK_ADDR}, {8'h00, CMD_BUF_LOAD});
    wr({start[23:16], 5'h00, UNLOCK_ADDR2}, 16'(n - 1));
    for (i = 0; i < n; i++) begin
      wr(start + 24'(i), d0 + 16'(i));
    end
  endtask

  // exit goes to an arbitrary address, also the recovery after a bad sequence
  task automatic leave();
    wr(24'h3a5a5a, {8'h00, CMD_EXIT});
  endtask
endmodule

// ---- tb/flash_mode_command_decoder_test.sv ----
// self-checking bench for the mode command decoder
// assumes the host model drives all bus cycles; bank state and read sources come from here
`timescale 1ns/10ps
module flash_mode_command_decoder_test;
  import flash_cmd_pkg::*;
  typedef struct packed {logic [23:0] a; logic [15:0] d; logic [1:0] m; logic s;} row_t;
  localparam row_t ROWS [13] = '{
    '{24'h000055, 16'h0090, RD_QUERY, 1'b0}, '{24'h3a5a5a, 16'h00f0, RD_ARRAY, 1'b0},
    '{24'h020055, 16'h0098, RD_QUERY, 1'b0}, '{24'h020555, 16'h0040, RD_QUERY, 1'b0},
    '{24'h123456, 16'hfff0, RD_ARRAY, 1'b0}, '{24'h000555, 16'h00d0, RD_CONFIG, 1'b0},
    '{24'h000555, 16'h0088, RD_CONFIG, 1'b0}, '{24'h000000, 16'h00f0, RD_ARRAY, 1'b0},
    '{24'h05f555, 16'hff40, RD_LOCK, 1'b0}, '{24'h000000, 16'h00f0, RD_ARRAY, 1'b0},
    '{24'h000554, 16'h0088, RD_ARRAY, 1'b0}, '{24'h000555, 16'h0088, RD_ARRAY, 1'b1},
    '{24'h000000, 16'h00f0, RD_ARRAY, 1'b0}};
  localparam logic [7:0]  Q_OFFS [7] = '{8'h10, 8'h11, 8'h12, 8'h15, 8'h17, 8'h19, 8'h02};
  localparam logic [15:0] Q_VALS [7] = '{Q_SIG_Q, Q_SIG_R, Q_SIG_Y, PRI_TABLE_ADDR, 16'h0000, 16'h0000, ID_FILL};
  logic        clock, reset, banks_idle, write, read, read_valid, secure_select, prog_word;
  logic        commit, prog_resume, erase_resume, blank_check, v;
  logic [23:0] address, target;
  logic [15:0] wdata, read_data, value, config_word, lock_word, array_data, secure_data, d;
  logic [1:0]  mode;
  int          errors, compares, words;

  host_model host (.i_clock(clock), .i_read_data(read_data), .i_read_valid(read_valid), .o_write(write),
    .o_read(read), .o_address(address), .o_data(wdata));
  flash_mode_command_decoder DUT (.i_clock(clock), .i_reset(reset), .i_write(write), .i_read(read),
    .i_address(address), .i_data(wdata), .i_banks_idle(banks_idle), .i_array_data(array_data),
    .i_secure_data(secure_data), .o_read_data(read_data), .o_read_valid(read_valid),
    .o_secure_select(secure_select), .o_prog_word(prog_word), .o_program_target_address(target),
    .o_program_write_value(value), .o_buffer_commit(commit), .o_prog_resume(prog_resume),
    .o_erase_resume(erase_resume), .o_blank_check(blank_check), .o_config_word(config_word),
    .o_lock_word(lock_word), .o_mode(mode));

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_word({15'h0000, got}, {15'h0000, exp}, what);
  endtask
  // a pulse or mode change is looked at just after the edge that took the write
  task automatic w(input logic [23:0] a, input logic [15:0] dd);
    host.wr(a, dd);
    #1;
  endtask
  task automatic done(input string name);
    $display("test %s finished, %0d mismatches so far", name, errors);
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    if (prog_word === 1'b1) words <= words + 1;
  end
  // whole run is well under 2000 cycles
  initial begin
    #100us;
    errors++;
    $display("wrong value at %0t: run did not finish", $time);
    results();
  end

  initial begin
    reset = 1'b1;
    banks_idle = 1'b1;
    array_data = 16'h3c5a;
    secure_data = 16'hc3a5;
    errors = 0;
    compares = 0;
    words = 0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk_word(config_word, CONFIG_RESET, "config reset");
    chk_word(lock_word, LOCK_RESET, "lock reset");
    chk_word({14'h0000, mode}, {14'h0000, RD_ARRAY}, "mode reset");
    done("reset");
    foreach (ROWS[i]) begin
      w(ROWS[i].a, ROWS[i].d);
      chk_word({14'h0000, mode}, {14'h0000, ROWS[i].m}, "mode");
      chk_bit(secure_select, ROWS[i].s, "secure select");
    end
    done("entry table");
    w(24'h000055, 16'h0090);
    foreach (Q_OFFS[i]) begin
      host.rd({16'h0000, Q_OFFS[i]}, d, v);
      chk_bit(v, 1'b1, "query valid");
      chk_word(d, Q_VALS[i], "query word");
    end
    host.leave();
    host.rd(24'h000010, d, v);
    chk_word(d, array_data, "array after query");
    done("query");
    banks_idle <= 1'b0;
    w(24'h000555, 16'h00d0);
    chk_word({14'h0000, mode}, {14'h0000, RD_ARRAY}, "entry while busy");
    w(24'h000055, 16'h0090);
    chk_word({14'h0000, mode}, {14'h0000, RD_ARRAY}, "query while busy");
    banks_idle <= 1'b1;
    done("busy banks");
    w(24'h000555, 16'h00d0);
    host.load(24'h000000, 1, 16'h1234);
    w(24'h000555, 16'h0029);
    chk_word(config_word, 16'h1234, "config commit");
    host.rd(24'h000000, d, v);
    chk_word(d, 16'h1234, "config read");
    host.leave();
    w(24'h000555, 16'h0033);
    chk_bit(blank_check, 1'b0, "blank check sync");
    w(24'h000555, 16'h00d0);
    host.load(24'h000000, 1, CONFIG_RESET);
    w(24'h000555, 16'h0029);
    host.leave();
    w(24'h000555, 16'h0033);
    chk_bit(blank_check, 1'b1, "blank check async");
    done("configuration");
    w(24'h000555, 16'h0040);
    host.load(24'h000000, 1, {8'h00, LOCK_SET_VALUE});
    w(24'h000555, 16'h0029);
    chk_word(lock_word, 16'hfffe, "lock set");
    host.rd(24'h000000, d, v);
    chk_word(d, 16'hfffe, "lock read");
    host.leave();
    done("lock");
    w(24'h000555, 16'h0088);
    host.rd(24'h000123, d, v);
    chk_word(d, secure_data, "secure read");
    words = 0;
    host.load(24'h000044, 4, 16'h0a00);
    @(posedge clock);
    #1;
    chk_word(16'(words), 16'h0004, "words taken");
    chk_word(target[15:0], 16'h0047, "last target");
    chk_word(value, 16'h0a03, "last value");
    w(24'h000555, 16'h0029);
    chk_bit(commit, 1'b1, "secure commit");
    host.leave();
    #1;
    chk_bit(secure_select, 1'b0, "secure left");
    done("secure buffer");
    w(24'h000555, 16'h0025);
    w(24'h0002aa, 16'h0003);
    w(24'h000010, 16'h5555);
    w(24'h000030, 16'h5556);
    chk_bit(prog_word, 1'b0, "word outside page");
    host.leave();
    host.rd(24'h000010, d, v);
    chk_word(d, array_data, "array after abort");
    done("abort");
    w(24'h000000, 16'h0050);
    chk_bit(prog_resume, 1'b0, "resume unsuspended");
    w(24'h000000, 16'h0030);
    chk_bit(erase_resume, 1'b0, "erase resume unsuspended");
    w(24'h000000, 16'h0051);
    w(24'h000000, 16'h0050);
    chk_bit(prog_resume, 1'b1, "resume suspended");
    w(24'h000000, 16'h00b0);
    w(24'h000000, 16'h0030);
    chk_bit(erase_resume, 1'b1, "erase resume suspended");
    done("resume");
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk_word(lock_word, LOCK_RESET, "lock after reset");
    chk_word({14'h0000, mode}, {14'h0000, RD_ARRAY}, "mode after reset");
    done("mid reset");
    results();
  end
endmodule
